/* core/gptu_pkg.sv */
// Purpose: constants for the general purpose timer unit
// Assumes: 16-bit register words, word-aligned byte offsets
// Notes: timer index 0 low aux, 1 core, 2 high aux, 3 second aux, 4 second core
package gptu_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int TIMERS = 5;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int PIN_W = 11;
  localparam int PRESC_W = 10;
  localparam int FLAG_W = 6;
  // ----------------------------------------
  // timer indices
  // ----------------------------------------
  localparam int IDX_LOW = 0;
  localparam int IDX_CORE = 1;
  localparam int IDX_HIGH = 2;
  localparam int IDX_SAUX = 3;
  localparam int IDX_SCORE = 4;
  localparam int FLAG_CAP = 5;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] CTRL_BASE = 8'h00;
  localparam logic [AW-1:0] CNT_BASE = 8'h20;
  localparam logic [AW-1:0] CAPTURE_REG_OFS = 8'h40;
  localparam logic [AW-1:0] CAPCTL_OFS = 8'h44;
  localparam logic [AW-1:0] FLAGS_OFS = 8'h48;
  localparam logic [AW-1:0] STATUS_OFS = 8'h4C;
  // ----------------------------------------
  // timer control fields
  // ----------------------------------------
  localparam int F_SEL_LSB = 0;
  localparam int F_MODE_LSB = 3;
  localparam int F_RUN = 6;
  localparam int F_DOWN = 7;
  localparam int F_EXTDIR = 8;
  localparam int F_OUTEN = 9;
  localparam int F_EDGE_LSB = 10;
  localparam int F_TOGSRC = 12;
  localparam int F_RELOAD = 13;
  // capture control fields
  localparam int C_EDGE_LSB = 0;
  localparam int C_SRC_LSB = 2;
  localparam int C_CLEAR = 4;
  // ----------------------------------------
  // modes and prescaler bases
  // ----------------------------------------
  localparam logic [2:0] M_TIMER = 3'h0;
  localparam logic [2:0] M_COUNT = 3'h1;
  localparam logic [2:0] M_GATE_LO = 3'h2;
  localparam logic [2:0] M_GATE_HI = 3'h3;
  localparam logic [2:0] M_CAPTURE = 3'h4;
  localparam logic [2:0] M_RELOAD = 3'h5;
  localparam logic [2:0] M_INCR = 3'h6;
  localparam int BASE_ONE = 3;
  localparam int BASE_TWO = 2;
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [DW-1:0] CNT_MAX = 16'hFFFF;
endpackage

/* core/gptu_top.sv */
// Purpose: two-module general purpose timer/counter unit
// Assumes: pins asynchronous to core_clk_in, registers on a plain strobe port
// Notes: second core timer overflow pulse feeds compare-unit timers
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module gptu_top #(
  parameter int PRESC_BITS = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [gptu_pkg::AW-1:0] addr_in,
  input wire logic [gptu_pkg::DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [gptu_pkg::DW-1:0] rdata_out,
  input wire logic [gptu_pkg::TIMERS-1:0] timer_input_pin_in,
  input wire logic [gptu_pkg::TIMERS-1:0] direction_input_pin_in,
  input wire logic capture_input_pin_in,
  output logic toggle_output_pin_out,
  output logic second_toggle_output_pin_out,
  output logic compare_unit_clk_out,
  output logic [gptu_pkg::FLAG_W-1:0] request_flags_out
);
  // tap masks assume exactly ten prescaler bits
  if (PRESC_BITS != gptu_pkg::PRESC_W) begin : g_bad_presc
    $error("prescaler width must cover division by 1024");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [gptu_pkg::DW-1:0] ctrl [gptu_pkg::TIMERS];
  logic [gptu_pkg::DW-1:0] cnt [gptu_pkg::TIMERS];
  logic [gptu_pkg::DW-1:0] capture_reload_register;
  logic [4:0] cap_ctrl;
  logic [gptu_pkg::FLAG_W-1:0] flags;
  logic core_toggle_latch;
  logic second_toggle_latch;
  logic core_tog_d;
  logic second_tog_d;
  logic [PRESC_BITS-1:0] presc;
  logic [gptu_pkg::PIN_W-1:0] pin_meta;
  logic [gptu_pkg::PIN_W-1:0] pin_s;
  logic [gptu_pkg::PIN_W-1:0] pin_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // meta stage feeds only pin_s; edges compare pin_s with pin_d
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '0;
      pin_s <= '0;
      pin_d <= '0;
    end else begin
      pin_meta <= {capture_input_pin_in, direction_input_pin_in, timer_input_pin_in};
      pin_s <= pin_meta;
      pin_d <= pin_s;
    end
  end

  logic [gptu_pkg::TIMERS-1:0] in_s;
  logic [gptu_pkg::TIMERS-1:0] in_d;
  logic [gptu_pkg::TIMERS-1:0] dir_s;
  logic [gptu_pkg::TIMERS-1:0] dir_d;
  logic cap_s;
  logic cap_d;
  assign in_s = pin_s[4:0];
  assign in_d = pin_d[4:0];
  assign dir_s = pin_s[9:5];
  assign dir_d = pin_d[9:5];
  assign cap_s = pin_s[10];
  assign cap_d = pin_d[10];

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // one free-running divider; taps give powers of two from 4 to 1024
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // ----------------------------------------
  // toggle latch edges
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_tog_d <= 1'b0;
      second_tog_d <= 1'b0;
    end else begin
      core_tog_d <= core_toggle_latch;
      second_tog_d <= second_toggle_latch;
    end
  end

  logic [gptu_pkg::TIMERS-1:0] tog_now;
  logic [gptu_pkg::TIMERS-1:0] tog_old;
  assign tog_now = {1'b0, second_toggle_latch, core_toggle_latch, 1'b0, core_toggle_latch};
  assign tog_old = {1'b0, second_tog_d, core_tog_d, 1'b0, core_tog_d};

  // ----------------------------------------
  // per-timer count logic
  // ----------------------------------------
  logic [gptu_pkg::TIMERS-1:0] step;
  logic [gptu_pkg::TIMERS-1:0] down;
  logic [gptu_pkg::TIMERS-1:0] ovf;
  logic [gptu_pkg::TIMERS-1:0] trig;
  logic [gptu_pkg::DW-1:0] stepped [gptu_pkg::TIMERS];

  genvar gi;
  generate
    for (gi = 0; gi < gptu_pkg::TIMERS; gi++) begin : g_tmr
      localparam int BASE = (gi >= gptu_pkg::IDX_SAUX) ? gptu_pkg::BASE_TWO : gptu_pkg::BASE_ONE;
      logic [2:0] sel;
      logic [2:0] mode;
      logic [1:0] edge_sel;
      logic use_tog;
      logic src_now;
      logic src_old;
      logic tick;
      logic quad_evt;
      logic quad_down;
      logic raw_step;
      logic [PRESC_BITS-1:0] mask;
      assign sel = ctrl[gi][gptu_pkg::F_SEL_LSB +: 3];
      assign mode = ctrl[gi][gptu_pkg::F_MODE_LSB +: 3];
      assign edge_sel = ctrl[gi][gptu_pkg::F_EDGE_LSB +: 2];
      assign use_tog = ctrl[gi][gptu_pkg::F_TOGSRC];
      // toggle latch may replace the pin as count or reload source
      assign src_now = use_tog ? tog_now[gi] : in_s[gi];
      assign src_old = use_tog ? tog_old[gi] : in_d[gi];
      assign trig[gi] = (edge_sel[0] & src_now & ~src_old) | (edge_sel[1] & ~src_now & src_old);
      // division 2^(BASE+sel): 8..1024 first module, 4..512 second
      assign mask = PRESC_BITS'((1 << (BASE + 32'(sel))) - 1);
      assign tick = ((presc & mask) == mask);
      assign quad_evt = (in_s[gi] ^ in_d[gi]) ^ (dir_s[gi] ^ dir_d[gi]);
      assign quad_down = ~(in_s[gi] ^ dir_d[gi]);
      always_comb begin
        raw_step = 1'b0;
        unique case (mode)
          gptu_pkg::M_TIMER: raw_step = tick;
          gptu_pkg::M_COUNT: raw_step = trig[gi];
          gptu_pkg::M_GATE_LO: raw_step = tick & ~in_s[gi];
          gptu_pkg::M_GATE_HI: raw_step = tick & in_s[gi];
          gptu_pkg::M_INCR: raw_step = quad_evt;
          default: raw_step = 1'b0;
        endcase
      end
      assign step[gi] = raw_step & ctrl[gi][gptu_pkg::F_RUN];
      assign down[gi] = (mode == gptu_pkg::M_INCR) ? (quad_down ^ ctrl[gi][gptu_pkg::F_DOWN]) :
        (ctrl[gi][gptu_pkg::F_DOWN] ^ (ctrl[gi][gptu_pkg::F_EXTDIR] & dir_s[gi]));
      assign ovf[gi] = step[gi] & (down[gi] ? (cnt[gi] == '0) : (cnt[gi] == gptu_pkg::CNT_MAX));
      assign stepped[gi] = down[gi] ? cnt[gi] - 1'b1 : cnt[gi] + 1'b1;
    end
  endgenerate

  // ----------------------------------------
  // capture and reload triggers
  // ----------------------------------------
  logic [gptu_pkg::TIMERS-1:0] ctl_wr;
  logic [gptu_pkg::TIMERS-1:0] cnt_wr;
  logic cap_evt;
  logic cap_pin_edge;
  logic core_in_edge;
  logic core_dir_edge;
  logic low_cap;
  logic high_cap;
  logic low_rel;
  logic high_rel;
  logic core_self_rel;

  assign cap_pin_edge = (cap_ctrl[gptu_pkg::C_EDGE_LSB] & cap_s & ~cap_d) |
    (cap_ctrl[gptu_pkg::C_EDGE_LSB + 1] & ~cap_s & cap_d);
  assign core_in_edge = in_s[gptu_pkg::IDX_CORE] ^ in_d[gptu_pkg::IDX_CORE];
  assign core_dir_edge = dir_s[gptu_pkg::IDX_CORE] ^ dir_d[gptu_pkg::IDX_CORE];
  always_comb begin
    cap_evt = 1'b0;
    unique case (cap_ctrl[gptu_pkg::C_SRC_LSB +: 2])
      2'h0: cap_evt = cap_pin_edge;
      2'h1: cap_evt = core_in_edge;
      2'h2: cap_evt = core_dir_edge;
      2'h3: cap_evt = core_in_edge | core_dir_edge;
    endcase
  end

  assign low_cap = (ctrl[gptu_pkg::IDX_LOW][gptu_pkg::F_MODE_LSB +: 3] == gptu_pkg::M_CAPTURE) &
    trig[gptu_pkg::IDX_LOW];
  assign high_cap = (ctrl[gptu_pkg::IDX_HIGH][gptu_pkg::F_MODE_LSB +: 3] == gptu_pkg::M_CAPTURE) &
    trig[gptu_pkg::IDX_HIGH];
  // trig already follows the latch when the toggle source bit is set
  assign low_rel = (ctrl[gptu_pkg::IDX_LOW][gptu_pkg::F_MODE_LSB +: 3] == gptu_pkg::M_RELOAD) &
    trig[gptu_pkg::IDX_LOW];
  assign high_rel = (ctrl[gptu_pkg::IDX_HIGH][gptu_pkg::F_MODE_LSB +: 3] == gptu_pkg::M_RELOAD) &
    trig[gptu_pkg::IDX_HIGH];
  assign core_self_rel = ovf[gptu_pkg::IDX_SCORE] & ctrl[gptu_pkg::IDX_SCORE][gptu_pkg::F_RELOAD];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  generate
    for (gi = 0; gi < gptu_pkg::TIMERS; gi++) begin : g_dec
      assign ctl_wr[gi] = wr_in & (addr_in == gptu_pkg::CTRL_BASE + gptu_pkg::AW'(4 * gi));
      assign cnt_wr[gi] = wr_in & (addr_in == gptu_pkg::CNT_BASE + gptu_pkg::AW'(4 * gi));
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < gptu_pkg::TIMERS; i++) begin
        ctrl[i] <= gptu_pkg::CTRL_RST;
      end
      cap_ctrl <= '0;
    end else begin
      for (int i = 0; i < gptu_pkg::TIMERS; i++) begin
        if (ctl_wr[i]) begin
          ctrl[i] <= wdata_in;
        end
      end
      if (wr_in && addr_in == gptu_pkg::CAPCTL_OFS) begin
        cap_ctrl <= wdata_in[4:0];
      end
    end
  end

  // ----------------------------------------
  // timer counters
  // ----------------------------------------
  // software write wins over any hardware load in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < gptu_pkg::TIMERS; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < gptu_pkg::TIMERS; i++) begin
        if (cnt_wr[i]) begin
          cnt[i] <= wdata_in;
        end else if (i == gptu_pkg::IDX_LOW && low_cap) begin
          cnt[i] <= cnt[gptu_pkg::IDX_CORE];
        end else if (i == gptu_pkg::IDX_HIGH && high_cap) begin
          cnt[i] <= cnt[gptu_pkg::IDX_CORE];
        end else if (i == gptu_pkg::IDX_CORE && low_rel) begin
          cnt[i] <= cnt[gptu_pkg::IDX_LOW];
        end else if (i == gptu_pkg::IDX_CORE && high_rel) begin
          cnt[i] <= cnt[gptu_pkg::IDX_HIGH];
        end else if (i == gptu_pkg::IDX_SAUX && cap_evt && cap_ctrl[gptu_pkg::C_CLEAR]) begin
          cnt[i] <= '0;
        end else if (i == gptu_pkg::IDX_SCORE && core_self_rel) begin
          cnt[i] <= capture_reload_register;
        end else if (step[i]) begin
          cnt[i] <= stepped[i];
        end
      end
    end
  end

  // ----------------------------------------
  // capture register
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_reload_register <= '0;
    end else if (wr_in && addr_in == gptu_pkg::CAPTURE_REG_OFS) begin
      capture_reload_register <= wdata_in;
    end else if (cap_evt) begin
      capture_reload_register <= cnt[gptu_pkg::IDX_SAUX];
    end
  end

  // ----------------------------------------
  // toggle latches and compare clock
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_toggle_latch <= 1'b0;
      second_toggle_latch <= 1'b0;
    end else begin
      if (wr_in && addr_in == gptu_pkg::STATUS_OFS) begin
        core_toggle_latch <= wdata_in[0];
        second_toggle_latch <= wdata_in[1];
      end else begin
        core_toggle_latch <= core_toggle_latch ^ ovf[gptu_pkg::IDX_CORE];
        second_toggle_latch <= second_toggle_latch ^ ovf[gptu_pkg::IDX_SCORE];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_unit_clk_out <= 1'b0;
      toggle_output_pin_out <= 1'b0;
      second_toggle_output_pin_out <= 1'b0;
    end else begin
      compare_unit_clk_out <= ovf[gptu_pkg::IDX_SCORE];
      toggle_output_pin_out <= core_toggle_latch & ctrl[gptu_pkg::IDX_CORE][gptu_pkg::F_OUTEN];
      second_toggle_output_pin_out <= second_toggle_latch &
        ctrl[gptu_pkg::IDX_SCORE][gptu_pkg::F_OUTEN];
    end
  end

  // ----------------------------------------
  // request flags
  // ----------------------------------------
  // write one to clear; a new event in the same cycle keeps its flag
  logic [gptu_pkg::FLAG_W-1:0] flag_set;
  logic [gptu_pkg::FLAG_W-1:0] flag_clr;
  assign flag_set = {cap_evt, ovf};
  assign flag_clr = (wr_in && addr_in == gptu_pkg::FLAGS_OFS) ? wdata_in[gptu_pkg::FLAG_W-1:0] : '0;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end
  assign request_flags_out = flags;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [gptu_pkg::DW-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < gptu_pkg::TIMERS; i++) begin
      if (addr_in == gptu_pkg::CTRL_BASE + gptu_pkg::AW'(4 * i)) begin
        next_rdata = ctrl[i];
      end
      if (addr_in == gptu_pkg::CNT_BASE + gptu_pkg::AW'(4 * i)) begin
        next_rdata = cnt[i];
      end
    end
    if (addr_in == gptu_pkg::CAPTURE_REG_OFS) begin
      next_rdata = capture_reload_register;
    end
    if (addr_in == gptu_pkg::CAPCTL_OFS) begin
      next_rdata = {11'h000, cap_ctrl};
    end
    if (addr_in == gptu_pkg::FLAGS_OFS) begin
      next_rdata = {10'h000, flags};
    end
    if (addr_in == gptu_pkg::STATUS_OFS) begin
      next_rdata = {14'h0000, second_toggle_latch, core_toggle_latch};
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end
endmodule

/* verification/gptu_assertions.sv */
// Purpose: port-level checks of the timer unit
// Assumes: one clock domain, async active-low reset
// Notes: bound into gptu_top, sees its ports only
`timescale 1ns/100ps
module gptu_assertions #(
  parameter int PRESC_BITS = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [gptu_pkg::AW-1:0] addr_in,
  input wire logic [gptu_pkg::DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [gptu_pkg::DW-1:0] rdata_out,
  input wire logic [gptu_pkg::TIMERS-1:0] timer_input_pin_in,
  input wire logic [gptu_pkg::TIMERS-1:0] direction_input_pin_in,
  input wire logic capture_input_pin_in,
  input wire logic toggle_output_pin_out,
  input wire logic second_toggle_output_pin_out,
  input wire logic compare_unit_clk_out,
  input wire logic [gptu_pkg::FLAG_W-1:0] request_flags_out
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside read cycle");
  AST_UNMAPPED_RD: assert property (rd_in && addr_in > gptu_pkg::STATUS_OFS |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  AST_FLAGS_RD: assert property (
    rd_in && addr_in == gptu_pkg::FLAGS_OFS |=> rdata_out == {10'h000, $past(request_flags_out)})
    else $error("flag read differs from flag pins");
  AST_FLAG_STICKY: assert property (
    |($past(request_flags_out) & ~request_flags_out) |-> $past(wr_in) && $past(addr_in) == gptu_pkg::FLAGS_OFS)
    else $error("flag dropped without clear write");
  AST_CMP_PULSE: assert property (compare_unit_clk_out |=> !compare_unit_clk_out)
    else $error("compare clock pulse longer than one cycle");
  AST_CMP_CAUSE: assert property (compare_unit_clk_out |-> request_flags_out[4])
    else $error("compare clock without second core overflow");
  AST_TOG_CAUSE: assert property (
    $changed(toggle_output_pin_out) |-> request_flags_out[1] || $past(wr_in) || $past(wr_in, 2))
    else $error("toggle output moved without core overflow");
  AST_STOG_CAUSE: assert property (
    $changed(second_toggle_output_pin_out) |-> request_flags_out[4] || $past(wr_in) || $past(wr_in, 2))
    else $error("second toggle output moved without overflow");
endmodule
bind gptu_top gptu_assertions #(.PRESC_BITS(PRESC_BITS)) gptu_assertions_i (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .timer_input_pin_in(timer_input_pin_in), .direction_input_pin_in(direction_input_pin_in),
  .capture_input_pin_in(capture_input_pin_in), .toggle_output_pin_out(toggle_output_pin_out),
  .second_toggle_output_pin_out(second_toggle_output_pin_out), .compare_unit_clk_out(compare_unit_clk_out),
  .request_flags_out(request_flags_out));

/* verification/gptu_pins.sv */
// Purpose: external event, gate, direction and sensor pins
// Assumes: bench asks for levels and sensor steps
// Notes: index 1 carries the quadrature sensor when enabled
`timescale 1ns/100ps
module gptu_pins (
  input wire logic core_clk_in,
  input wire logic [gptu_pkg::TIMERS-1:0] pin_lvl_in,
  input wire logic [gptu_pkg::TIMERS-1:0] dir_lvl_in,
  input wire logic cap_lvl_in,
  input wire logic quad_en_in,
  input wire logic step_in,
  input wire logic back_in,
  output logic [gptu_pkg::TIMERS-1:0] timer_input_pin_out,
  output logic [gptu_pkg::TIMERS-1:0] direction_input_pin_out,
  output logic capture_input_pin_out
);
  logic [1:0] phase = 2'h0;
  initial begin
    timer_input_pin_out = '0;
    direction_input_pin_out = '0;
    capture_input_pin_out = 1'b0;
  end
  always @(posedge core_clk_in) begin
    if (step_in) begin
      phase <= back_in ? phase - 2'h1 : phase + 2'h1;
    end
  end
  // pins move on the falling edge, half a cycle away from the block's sampling edge
  always @(negedge core_clk_in) begin
    timer_input_pin_out <= pin_lvl_in;
    direction_input_pin_out <= dir_lvl_in;
    capture_input_pin_out <= cap_lvl_in;
    if (quad_en_in) begin
      timer_input_pin_out[1] <= phase[1] ^ phase[0];
      direction_input_pin_out[1] <= phase[1];
    end
  end
endmodule

/* verification/tb.sv */
// Purpose: self-checking bench of the timer unit
// Assumes: register port with one-cycle read data
// Notes: rate checks use read pairs a whole number of periods apart
`timescale 1ns/100ps
module tb;
  typedef logic [gptu_pkg::AW-1:0] gptu_addr_t;
  typedef logic [gptu_pkg::DW-1:0] gptu_word_t;
  typedef struct {int idx; gptu_word_t ctrl; int span; gptu_word_t exp;} gptu_row_s;
  localparam gptu_word_t RUN = 16'h0001 << gptu_pkg::F_RUN;
  localparam gptu_word_t RISE = 16'h0001 << gptu_pkg::F_EDGE_LSB;
  localparam gptu_word_t OUTEN = 16'h0001 << gptu_pkg::F_OUTEN;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  gptu_addr_t addr_in = 8'h00;
  gptu_word_t wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  gptu_word_t rdata_out;
  logic [4:0] tin, din, pin_lvl = 5'h00, dir_lvl = 5'h00;
  logic cin, cap_lvl = 1'b0, quad_en = 1'b0, step = 1'b0, back = 1'b0;
  logic tog, stog, cmp, seen;
  logic [5:0] flags;
  int n_fail = 0;
  int num_checks = 0;
  gptu_word_t v0, v1;
  gptu_row_s rows[20];
  always #20 core_clk_in = ~core_clk_in;
  gptu_pins gptu_pins_i (.core_clk_in(core_clk_in), .pin_lvl_in(pin_lvl), .dir_lvl_in(dir_lvl),
    .cap_lvl_in(cap_lvl), .quad_en_in(quad_en), .step_in(step), .back_in(back),
    .timer_input_pin_out(tin), .direction_input_pin_out(din), .capture_input_pin_out(cin));
  gptu_top #(.PRESC_BITS(10)) gptu_top_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .timer_input_pin_in(tin),
    .direction_input_pin_in(din), .capture_input_pin_in(cin), .toggle_output_pin_out(tog),
    .second_toggle_output_pin_out(stog), .compare_unit_clk_out(cmp), .request_flags_out(flags));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic gptu_addr_t ca(input int i);
    return gptu_pkg::CTRL_BASE + 8'(4 * i);
  endfunction
  function automatic gptu_addr_t na(input int i);
    return gptu_pkg::CNT_BASE + 8'(4 * i);
  endfunction
  function automatic gptu_word_t md(input logic [2:0] m);
    return 16'(m) << gptu_pkg::F_MODE_LSB;
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input gptu_word_t got, input gptu_word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic wr(input gptu_addr_t a, input gptu_word_t d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdv(input gptu_addr_t a, output gptu_word_t v);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic rdc(input gptu_addr_t a, input gptu_word_t e);
    gptu_word_t v;
    rdv(a, v);
    chk(v, e);
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk_in) pin_lvl[i] <= 1'b1;
    cyc(4);
    pin_lvl[i] <= 1'b0;
    cyc(4);
  endtask
  task automatic st(input logic b);
    @(posedge core_clk_in) step <= 1'b1;
    back <= b;
    @(posedge core_clk_in) step <= 1'b0;
    cyc(4);
  endtask
  // watchdog well beyond the roughly 6600 cycles of the run
  initial begin
    #800000;
    n_fail++;
    stop_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    for (int s = 0; s < 8; s++) begin
      rows[s] = '{1, RUN | 16'(s), 2 * (8 << s), 16'h0002};
      rows[8 + s] = '{4, RUN | 16'(s), 2 * (4 << s), 16'h0002};
    end
    rows[16] = '{0, RUN | (16'h0001 << gptu_pkg::F_DOWN), 16, 16'hFFFE};
    rows[17] = '{2, RUN | (16'h0001 << gptu_pkg::F_EXTDIR), 16, 16'hFFFE};
    rows[18] = '{3, RUN | 16'h0001, 16, 16'h0002};
    rows[19] = '{0, RUN | md(gptu_pkg::M_GATE_LO), 16, 16'h0002};
    dir_lvl <= 5'h04;
    cyc(6);
    rst_n_in <= 1'b1;
    rdc(ca(1), gptu_pkg::CTRL_RST);
    rdc(gptu_pkg::FLAGS_OFS, 16'h0000);
    rdc(8'h50, 16'h0000);
    foreach (rows[r]) begin
      wr(ca(rows[r].idx), rows[r].ctrl);
      rdv(na(rows[r].idx), v0);
      cyc(rows[r].span - 2);
      rdv(na(rows[r].idx), v1);
      chk(v1 - v0, rows[r].exp);
      wr(ca(rows[r].idx), 16'h0000);
    end
    wr(na(1), 16'h0000);
    wr(ca(1), RUN | md(gptu_pkg::M_COUNT) | RISE);
    repeat (3) pulse(1);
    rdc(na(1), 16'h0003);
    wr(ca(1), RUN | md(gptu_pkg::M_GATE_HI));
    rdv(na(1), v0);
    cyc(14);
    rdv(na(1), v1);
    chk(v1 - v0, 16'h0000);
    pin_lvl[1] <= 1'b1;
    cyc(4);
    rdv(na(1), v0);
    cyc(14);
    rdv(na(1), v1);
    chk(v1 - v0, 16'h0002);
    pin_lvl[1] <= 1'b0;
    wr(gptu_pkg::FLAGS_OFS, 16'h003F);
    wr(na(2), 16'h0000);
    wr(ca(2), RUN | md(gptu_pkg::M_COUNT) | (16'h0003 << gptu_pkg::F_EDGE_LSB) | (16'h0001 << gptu_pkg::F_TOGSRC));
    wr(na(1), 16'hFFFE);
    wr(ca(1), RUN | OUTEN);
    cyc(24);
    rdv(gptu_pkg::FLAGS_OFS, v0);
    chk(v0 & 16'h0002, 16'h0002);
    chk(16'(tog), 16'h0001);
    rdc(na(2), 16'h0001);
    wr(ca(1), 16'h0000);
    wr(na(1), 16'h0000);
    quad_en <= 1'b1;
    wr(ca(1), RUN | md(gptu_pkg::M_INCR));
    repeat (4) st(1'b0);
    rdc(na(1), 16'h0004);
    repeat (2) st(1'b1);
    rdc(na(1), 16'h0002);
    wr(ca(1), 16'h0000);
    quad_en <= 1'b0;
    wr(na(1), 16'h1234);
    wr(ca(0), RUN | md(gptu_pkg::M_CAPTURE) | RISE);
    pulse(0);
    rdc(na(0), 16'h1234);
    cyc(20);
    rdc(na(0), 16'h1234);
    wr(ca(0), RUN | md(gptu_pkg::M_RELOAD) | RISE);
    wr(na(0), 16'h0555);
    pulse(0);
    rdc(na(1), 16'h0555);
    wr(na(3), 16'h0ABC);
    wr(gptu_pkg::CAPCTL_OFS, 16'h0011);
    @(posedge core_clk_in) cap_lvl <= 1'b1;
    cyc(4);
    cap_lvl <= 1'b0;
    cyc(4);
    rdc(gptu_pkg::CAPTURE_REG_OFS, 16'h0ABC);
    rdc(na(3), 16'h0000);
    rdv(gptu_pkg::FLAGS_OFS, v0);
    chk(v0 & 16'h0020, 16'h0020);
    chk(16'(flags) & 16'h0020, 16'h0020);
    wr(na(3), 16'h0777);
    wr(gptu_pkg::CAPCTL_OFS, 16'h0004);
    pulse(1);
    rdc(gptu_pkg::CAPTURE_REG_OFS, 16'h0777);
    rdc(na(3), 16'h0777);
    wr(gptu_pkg::CAPTURE_REG_OFS, 16'h1000);
    wr(na(4), 16'hFFFF);
    wr(ca(4), RUN | OUTEN | (16'h0001 << gptu_pkg::F_RELOAD));
    seen = 1'b0;
    repeat (40) begin
      @(posedge core_clk_in);
      #1 if (cmp === 1'b1) seen = 1'b1;
    end
    chk(16'(seen), 16'h0001);
    chk(16'(stog), 16'h0001);
    rdv(na(4), v0);
    chk(v0 & 16'hFF00, 16'h1000);
    @(posedge core_clk_in) rst_n_in <= 1'b0;
    cyc(2);
    rst_n_in <= 1'b1;
    rdc(na(4), 16'h0000);
    rdc(gptu_pkg::FLAGS_OFS, 16'h0000);
    stop_test();
  end
endmodule
